/* sensor_fault_flag_registers.sv */
`default_nettype none
`include "fault_flag_defs.svh"
module sensor_fault_flag_registers
   import fault_flag_pkg::*;
(
   // clock and reset
   input wire logic clock_in,
   input wire logic resetn_in,
   // register access
   input wire fault_flag_pkg::reg_req_s req_in,
   output logic [15:0] rdata_out,
   output logic rvalid_out,
   // condition inputs
   input wire fault_flag_pkg::error_events_s err_ev_in,
   input wire fault_flag_pkg::warning_events_s warn_ev_in,
   input wire fault_flag_pkg::nvm_load_s nvm_in,
   input wire logic [11:0] field_magnitude_in,
   // nonvolatile configuration
   input wire logic warning_summary_mask_in,
   input wire logic crc_check_enable_in,
   input wire logic [11:0] field_low_threshold_in,
   input wire logic [11:0] error_mask_in,
   input wire logic [11:0] warning_mask_in,
   // summary
   output logic error_summary_flag_out,
   output logic packet_discard_out
);
   import fault_flag_pkg::*;

   // ***************************************************************
   // reset release
   // ***************************************************************
   logic rst_sync1_q;
   logic rst_n_q;
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rst_sync1_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_sync1_q <= 1'b1;
         rst_n_q <= rst_sync1_q;
      end
   end

   // ***************************************************************
   // decode
   // ***************************************************************
   function automatic logic hit(input reg_req_s r, input logic [7:0] a);
      hit = (r.addr == a);
   endfunction : hit

   logic read_err;
   logic read_warn;
   logic clear_err;
   logic clear_warn;
   logic nvm_loaded_q;
   logic [11:0] err_set;
   logic [11:0] warn_set;
   logic [11:0] err_flags;
   logic [11:0] warn_flags;
   logic warn_any;

   assign read_err = req_in.rd && hit(req_in, `ADDR_ERROR_FLAGS);
   assign read_warn = req_in.rd && hit(req_in, `ADDR_WARNING_FLAGS);
   assign clear_err = req_in.wr && hit(req_in, `ADDR_CTRL)
      && req_in.wdata[`CTRL_CLEAR_ERROR_BIT];
   assign clear_warn = req_in.wr && hit(req_in, `ADDR_CTRL)
      && req_in.wdata[`CTRL_CLEAR_WARNING_BIT];

   // ***************************************************************
   // ecc result taken from the first load after reset only
   // ***************************************************************
   // load-only ecc check
   always_ff @(posedge clock_in or negedge rst_n_q) begin
      if (!rst_n_q) begin
         nvm_loaded_q <= 1'b0;
      end else if (nvm_in.valid) begin
         nvm_loaded_q <= 1'b1;
      end
   end

   // ***************************************************************
   // set terms
   // ***************************************************************
   logic nvm_take;
   assign nvm_take = nvm_in.valid && !nvm_loaded_q;

   always_comb begin
      err_set = 12'h000;
      err_set[`ERR_WARNING_SUMMARY] = warn_any && !warning_summary_mask_in;
      err_set[`ERR_SELFTEST_FAIL] = err_ev_in.logic_self_test_fail || err_ev_in.frontend_selftest_fail;
      err_set[`ERR_AVERAGING_FAULT] = err_ev_in.averaging_fault;
      err_set[`ERR_QUADRATURE] = err_ev_in.quadrature_fault;
      err_set[`ERR_PLL_UNLOCKED] = err_ev_in.pll_unlocked;
      err_set[`ERR_ZERO_CROSS] = err_ev_in.zero_cross_timeout;
      err_set[`ERR_NVM_UNCORRECTABLE] = nvm_take && nvm_in.multi_bit;
      err_set[`ERR_OSCILLATOR] = err_ev_in.oscillator_hf_fault || err_ev_in.oscillator_lf_fault;
      err_set[`ERR_SUPPLY_UV] = err_ev_in.supply_undervoltage;
      err_set[`ERR_REGULATOR_UV] = err_ev_in.regulator_undervoltage;
      err_set[`ERR_FIELD_LOW] = err_ev_in.field_low_fault
         || (field_magnitude_in < field_low_threshold_in);
      err_set[`ERR_RESET] = err_ev_in.hard_reset;
   end

   always_comb begin
      warn_set = 12'h000;
      warn_set[`WARN_INTERFACE] = warn_ev_in.bit_count_fault || warn_ev_in.data_bit15_set
         || warn_ev_in.manchester_fault;
      warn_set[`WARN_CRC] = warn_ev_in.crc_bad && crc_check_enable_in;
      warn_set[`WARN_SLEW] = warn_ev_in.slew_limit_active;
      warn_set[`WARN_EXTENDED] = warn_ev_in.extended_exec_fault;
      warn_set[`WARN_TEMPERATURE] = warn_ev_in.temperature_out_of_range;
      warn_set[`WARN_NVM_CORRECTED] = nvm_take && nvm_in.single_bit;
      warn_set[`WARN_SATURATION] = warn_ev_in.signal_saturation;
   end

   // ***************************************************************
   // flag storage
   // ***************************************************************
   // unimplemented positions never set, so they always read zero
   localparam logic [11:0] err_live = `ERR_LIVE_MASK;
   localparam logic [11:0] warn_live = `WARN_LIVE_MASK;

   genvar gi;
   generate
      for (gi = 0; gi < `FLAG_WIDTH; gi = gi + 1) begin : g_flags
         flag_cell u_err (
            .clock_in(clock_in),
            .rst_n_in(rst_n_q),
            .init_in(gi == `ERR_RESET),
            .set_in(err_set[gi] && err_live[gi]),
            .capture_in(read_err),
            .clear_in(clear_err),
            .flag_out(err_flags[gi])
         );
         flag_cell u_warn (
            .clock_in(clock_in),
            .rst_n_in(rst_n_q),
            .init_in(1'b0),
            .set_in(warn_set[gi] && warn_live[gi]),
            .capture_in(read_warn),
            .clear_in(clear_warn),
            .flag_out(warn_flags[gi])
         );
      end
   endgenerate

   assign warn_any = |(warn_flags & ~warning_mask_in);

   // ***************************************************************
   // read port and summary
   // ***************************************************************
   always_ff @(posedge clock_in or negedge rst_n_q) begin
      if (!rst_n_q) begin
         rdata_out <= 16'h0000;
         rvalid_out <= 1'b0;
      end else begin
         rvalid_out <= req_in.rd;
         if (read_err) begin
            rdata_out <= {`ERROR_ID_NIBBLE, err_flags};
         end else if (read_warn) begin
            rdata_out <= {`WARNING_ID_NIBBLE, warn_flags & `WARN_LIVE_MASK};
         end else begin
            // control bits are write-only and read zero
            rdata_out <= 16'h0000;
         end
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_q) begin
      if (!rst_n_q) begin
         error_summary_flag_out <= 1'b1;
      end else begin
         error_summary_flag_out <= |(err_flags & ~error_mask_in) || warn_any;
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_q) begin
      if (!rst_n_q) begin
         packet_discard_out <= 1'b0;
      end else begin
         packet_discard_out <= warn_set[`WARN_INTERFACE] || warn_set[`WARN_CRC];
      end
   end

   // ***************************************************************
   // checks
   // ***************************************************************
   a_err_id_read: assert property (@(posedge clock_in) disable iff (!rst_n_q)
      read_err |=> rdata_out[15:12] == 4'ha)
      else $error("bad error id");
   a_warn_id_read: assert property (@(posedge clock_in) disable iff (!rst_n_q)
      read_warn |=> rdata_out[15:12] == 4'hb && !rdata_out[9])
      else $error("bad warning id");
   a_supply_uv_set: assert property (@(posedge clock_in) disable iff (!rst_n_q)
      err_ev_in.supply_undervoltage |=> err_flags[3])
      else $error("uv flag not set");
   a_crc_gated: assert property (@(posedge clock_in) disable iff (!rst_n_q)
      (warn_ev_in.crc_bad && !crc_check_enable_in && !warn_flags[10]
       && !$past(warn_flags[10])) |=> !warn_flags[10])
      else $error("crc flagged while disabled");
   a_selftest_set: assert property (@(posedge clock_in) disable iff (!rst_n_q)
      err_ev_in.logic_self_test_fail |=> err_flags[10])
      else $error("self-test flag missing");
   a_summary_flag: assert property (@(posedge clock_in) disable iff (!rst_n_q)
      (warn_any) |=> error_summary_flag_out)
      else $error("summary flag low");
   a_clear_read_err: assert property (@(posedge clock_in) disable iff (!rst_n_q)
      (read_err && err_flags[6] && !err_set[6]) ##1 !clear_err
      ##1 (clear_err && !err_set[6] && !read_err) |=> !err_flags[6])
      else $error("read error not cleared");
   a_warn_summary: assert property (@(posedge clock_in) disable iff (!rst_n_q)
      (warn_any && !warning_summary_mask_in) |=> err_flags[11])
      else $error("warning summary missing");
   a_clear_read_warn: assert property (@(posedge clock_in) disable iff (!rst_n_q)
      (read_warn && warn_flags[4] && !warn_set[4]) ##1 !clear_warn
      ##1 (clear_warn && !warn_set[4] && !read_warn) |=> !warn_flags[4])
      else $error("read warning not cleared");
   a_nvm_load_only: assert property (@(posedge clock_in) disable iff (!rst_n_q)
      (nvm_loaded_q && !err_flags[5] && !warn_flags[5]) |=> !err_flags[5] && !warn_flags[5])
      else $error("ecc flag set after load");
   a_field_low_set: assert property (@(posedge clock_in) disable iff (!rst_n_q)
      (field_magnitude_in < field_low_threshold_in) |=> err_flags[1])
      else $error("field low flag missing");
   a_osc_fault_set: assert property (@(posedge clock_in) disable iff (!rst_n_q)
      (err_ev_in.oscillator_hf_fault || err_ev_in.oscillator_lf_fault) |=> err_flags[4])
      else $error("oscillator flag missing");
   a_iface_fault_set: assert property (@(posedge clock_in) disable iff (!rst_n_q)
      (warn_ev_in.bit_count_fault || warn_ev_in.data_bit15_set || warn_ev_in.manchester_fault)
      |=> warn_flags[11])
      else $error("interface flag missing");
   a_reg_uv_set: assert property (@(posedge clock_in) disable iff (!rst_n_q)
      err_ev_in.regulator_undervoltage |=> err_flags[2])
      else $error("regulator uv flag missing");
   a_ctrl_read_zero: assert property (@(posedge clock_in) disable iff (!rst_n_q)
      (req_in.rd && hit(req_in, `ADDR_CTRL)) |=> rdata_out == 16'h0000)
      else $error("control clear bits read back");
   a_crc_discard: assert property (@(posedge clock_in) disable iff (!rst_n_q)
      (warn_ev_in.crc_bad && crc_check_enable_in) |=> packet_discard_out)
      else $error("bad crc packet kept");
   a_pll_unlock_set: assert property (@(posedge clock_in) disable iff (!rst_n_q)
      err_ev_in.pll_unlocked |=> err_flags[7])
      else $error("pll flag missing");
   a_avg_fault_set: assert property (@(posedge clock_in) disable iff (!rst_n_q)
      err_ev_in.averaging_fault |=> err_flags[9])
      else $error("averaging flag missing");
   a_quad_fault_set: assert property (@(posedge clock_in) disable iff (!rst_n_q)
      err_ev_in.quadrature_fault |=> err_flags[8])
      else $error("quadrature flag missing");
   a_zero_cross_set: assert property (@(posedge clock_in) disable iff (!rst_n_q)
      err_ev_in.zero_cross_timeout |=> err_flags[6])
      else $error("zero-crossing flag missing");
endmodule : sensor_fault_flag_registers
`default_nettype wire

/* fault_flag_defs.svh */
`ifndef FAULT_FLAG_DEFS_SVH
`define FAULT_FLAG_DEFS_SVH
// ***************************************************************
// register map and field positions
// ***************************************************************
`define ADDR_CTRL 8'h1e
`define ADDR_ERROR_FLAGS 8'h24
`define ADDR_WARNING_FLAGS 8'h26
`define ERROR_ID_NIBBLE 4'ha
`define WARNING_ID_NIBBLE 4'hb
`define CTRL_CLEAR_ERROR_BIT 8
`define CTRL_CLEAR_WARNING_BIT 9
`define ERR_WARNING_SUMMARY 11
`define ERR_SELFTEST_FAIL 10
`define ERR_AVERAGING_FAULT 9
`define ERR_QUADRATURE 8
`define ERR_PLL_UNLOCKED 7
`define ERR_ZERO_CROSS 6
`define ERR_NVM_UNCORRECTABLE 5
`define ERR_OSCILLATOR 4
`define ERR_SUPPLY_UV 3
`define ERR_REGULATOR_UV 2
`define ERR_FIELD_LOW 1
`define ERR_RESET 0
`define WARN_INTERFACE 11
`define WARN_CRC 10
`define WARN_SLEW 8
`define WARN_EXTENDED 7
`define WARN_TEMPERATURE 6
`define WARN_NVM_CORRECTED 5
`define WARN_SATURATION 4
// 12 flag bits below the identifier nibble, all 12 live for errors, 7 live for warnings
`define FLAG_WIDTH 12
`define WARN_LIVE_MASK 12'hdf0
`define ERR_LIVE_MASK 12'hfff
`endif

/* fault_flag_pkg.sv */
`default_nettype none
package fault_flag_pkg;
   // ***************************************************************
   // event carriers
   // ***************************************************************
   typedef struct packed {
      logic logic_self_test_fail;
      logic frontend_selftest_fail;
      logic averaging_fault;
      logic quadrature_fault;
      logic pll_unlocked;
      logic zero_cross_timeout;
      logic oscillator_hf_fault;
      logic oscillator_lf_fault;
      logic supply_undervoltage;
      logic regulator_undervoltage;
      logic field_low_fault;
      logic hard_reset;
   } error_events_s;

   typedef struct packed {
      logic bit_count_fault;
      logic data_bit15_set;
      logic manchester_fault;
      logic crc_bad;
      logic slew_limit_active;
      logic extended_exec_fault;
      logic temperature_out_of_range;
      logic signal_saturation;
   } warning_events_s;

   typedef struct packed {
      logic valid;
      logic single_bit;
      logic multi_bit;
   } nvm_load_s;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [15:0] wdata;
   } reg_req_s;
endpackage : fault_flag_pkg
`default_nettype wire

/* flag_cell.sv */
`default_nettype none
`include "fault_flag_defs.svh"
// one sticky flag: set wins over a read-qualified clear
module flag_cell (
   // clock and reset
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic init_in,
   // control
   input wire logic set_in,
   input wire logic capture_in,
   input wire logic clear_in,
   // state
   output logic flag_out
);
   logic seen_q;
   logic fresh_q;

   // one-cycle marker after reset, so the reset branch stays constant
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         fresh_q <= 1'b1;
      end else begin
         fresh_q <= 1'b0;
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         flag_out <= 1'b0;
      end else if (set_in || (init_in && fresh_q)) begin
         flag_out <= 1'b1;
      end else if (clear_in && seen_q) begin
         flag_out <= 1'b0;
      end
   end

   // remember whether the last read showed this flag set
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         seen_q <= 1'b0;
      end else if (capture_in) begin
         seen_q <= flag_out;
      end else if (clear_in) begin
         seen_q <= 1'b0;
      end
   end

   a_set_wins: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      set_in |=> flag_out)
      else $error("flag lost on set");
endmodule : flag_cell
`default_nettype wire

/* fault_host_model.sv */
`default_nettype none
`include "fault_flag_defs.svh"
module fault_host_model
   import fault_flag_pkg::*;
(
   // register port
   input wire logic clock_in,
   output var fault_flag_pkg::reg_req_s req_out,
   input wire logic [15:0] rdata_in,
   input wire logic rvalid_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****
   // host access
   // ****
   initial req_out = '0;
   // missing rvalid yields x so a lost answer never matches
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(negedge clock_in);
      req_out.rd = 1'b1;
      req_out.addr = a;
      @(negedge clock_in);
      d = rvalid_in ? rdata_in : 16'hxxxx;
      req_out.rd = 1'b0;
      req_out.addr = ~a;
   endtask : rd
   task automatic wr(input logic [15:0] v);
      @(negedge clock_in);
      req_out.wr = 1'b1;
      req_out.addr = `ADDR_CTRL;
      req_out.wdata = v;
      @(negedge clock_in);
      req_out.wr = 1'b0;
      req_out.wdata = ~v;
   endtask : wr
   // read and clear everything
   // warnings go first so the summary bit does not re-set errors
   task automatic clr_all();
      logic [15:0] d;
      rd(`ADDR_WARNING_FLAGS, d);
      wr(16'h0200);
      rd(`ADDR_ERROR_FLAGS, d);
      wr(16'h0100);
   endtask : clr_all
endmodule : fault_host_model
`default_nettype wire

/* sensor_fault_flag_registers_test.sv */
`default_nettype none
`include "fault_flag_defs.svh"
module sensor_fault_flag_registers_test import fault_flag_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock_in = 1'b0;
   logic resetn_in = 1'b0;
   reg_req_s req;
   logic [15:0] rdata;
   logic [15:0] d;
   logic rvalid;
   logic esf;
   logic discard;
   logic seen_disc;
   logic wsm = 1'b0;
   logic crc_en = 1'b0;
   error_events_s eev = '0;
   warning_events_s wev = '0;
   nvm_load_s nvm = '0;
   logic [11:0] mag = 12'hfff;
   logic [11:0] emask = '0;
   logic [11:0] wmask = '0;
   int error_cnt = 0;
   int comparisons = 0;
   int ebit [12] = '{0, 1, 2, 3, 4, 4, 6, 7, 8, 9, 10, 10};
   int wbit [8] = '{4, 6, 7, 8, 10, 11, 11, 11};
   // ****
   // design and host
   // ****
   sensor_fault_flag_registers sensor_fault_flag_registers_i (
      .clock_in(clock_in), .resetn_in(resetn_in), .req_in(req),
      .rdata_out(rdata), .rvalid_out(rvalid), .err_ev_in(eev),
      .warn_ev_in(wev), .nvm_in(nvm), .field_magnitude_in(mag),
      .warning_summary_mask_in(wsm), .crc_check_enable_in(crc_en),
      .field_low_threshold_in(12'h0c8), .error_mask_in(emask),
      .warning_mask_in(wmask), .error_summary_flag_out(esf),
      .packet_discard_out(discard));
   fault_host_model fault_host_model_i (.clock_in(clock_in), .req_out(req),
      .rdata_in(rdata), .rvalid_in(rvalid));
   initial begin
      forever #5 clock_in = ~clock_in;
   end
   // ****
   // helpers
   // ****
   task automatic check(input logic [15:0] s, input logic [15:0] e);
      comparisons++;
      if (s !== e) begin
         error_cnt++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : check
   task automatic rchk(input logic [7:0] a, input logic [15:0] e);
      fault_host_model_i.rd(a, d);
      check(d, e);
   endtask : rchk
   // one cycle of events; discard is sampled in the cycle after
   task automatic pulse(input logic [22:0] v);
      @(negedge clock_in);
      {eev, wev, nvm} = v;
      @(negedge clock_in);
      seen_disc = discard;
      {eev, wev, nvm} = '0;
   endtask : pulse
   task automatic done(input string n);
      $display("test %s done", n);
   endtask : done
   task automatic give_verdict();
      $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : give_verdict
   initial begin
      #50us;
      error_cnt++;
      give_verdict();
   end
   // ****
   // tests
   // ****
   initial begin
      repeat (8) @(negedge clock_in);
      check({15'h0, esf}, 16'h1);
      repeat (8) @(negedge clock_in);
      resetn_in = 1'b1;
      repeat (4) @(negedge clock_in);
      pulse(23'h7);
      rchk(`ADDR_ERROR_FLAGS, 16'ha821);
      check({15'h0, esf}, 16'h1);
      rchk(`ADDR_WARNING_FLAGS, 16'hb020);
      rchk(8'h28, 16'h0000);
      rchk(`ADDR_CTRL, 16'h0000);
      fault_host_model_i.clr_all();
      rchk(`ADDR_ERROR_FLAGS, 16'ha000);
      check({15'h0, esf}, 16'h0);
      pulse(23'h7);
      rchk(`ADDR_ERROR_FLAGS, 16'ha000);
      done("boot");
      for (int i = 0; i < 12; i++) begin
         pulse(23'h1 << (11 + i));
         repeat (2) @(negedge clock_in);
         rchk(`ADDR_ERROR_FLAGS, 16'ha000 | (16'h1 << ebit[i]));
         check({15'h0, seen_disc}, 16'h0);
         fault_host_model_i.clr_all();
      end
      done("errors");
      crc_en = 1'b1;
      for (int i = 0; i < 8; i++) begin
         pulse(23'h1 << (3 + i));
         check({15'h0, seen_disc}, {15'h0, i > 3});
         rchk(`ADDR_WARNING_FLAGS, 16'hb000 | (16'h1 << wbit[i]));
         rchk(`ADDR_ERROR_FLAGS, 16'ha800);
         fault_host_model_i.clr_all();
      end
      crc_en = 1'b0;
      pulse(23'h80);
      check({15'h0, seen_disc}, 16'h0);
      rchk(`ADDR_WARNING_FLAGS, 16'hb000);
      wsm = 1'b1;
      pulse(23'h40);
      rchk(`ADDR_ERROR_FLAGS, 16'ha000);
      rchk(`ADDR_WARNING_FLAGS, 16'hb100);
      fault_host_model_i.clr_all();
      wsm = 1'b0;
      wmask = 12'hfff;
      pulse(23'h08);
      rchk(`ADDR_ERROR_FLAGS, 16'ha000);
      check({15'h0, esf}, 16'h0);
      rchk(`ADDR_WARNING_FLAGS, 16'hb010);
      wmask = 12'h000;
      fault_host_model_i.clr_all();
      done("warnings");
      pulse(23'h1 << 18);
      fault_host_model_i.rd(`ADDR_ERROR_FLAGS, d);
      pulse(23'h1 << 20);
      fault_host_model_i.wr(16'h0100);
      rchk(`ADDR_ERROR_FLAGS, 16'ha200);
      pulse(23'h10);
      fault_host_model_i.rd(`ADDR_WARNING_FLAGS, d);
      pulse(23'h08);
      fault_host_model_i.wr(16'h0200);
      rchk(`ADDR_WARNING_FLAGS, 16'hb010);
      fault_host_model_i.clr_all();
      done("seen clear");
      @(negedge clock_in);
      eev.supply_undervoltage = 1'b1;
      fault_host_model_i.rd(`ADDR_ERROR_FLAGS, d);
      fault_host_model_i.wr(16'h0100);
      rchk(`ADDR_ERROR_FLAGS, 16'ha008);
      eev = '0;
      fault_host_model_i.clr_all();
      mag = 12'h0c8;
      rchk(`ADDR_ERROR_FLAGS, 16'ha000);
      mag = 12'h0c7;
      rchk(`ADDR_ERROR_FLAGS, 16'ha002);
      mag = 12'hfff;
      fault_host_model_i.clr_all();
      pulse(23'h1 << 18);
      emask = 12'hfff;
      repeat (3) @(negedge clock_in);
      check({15'h0, esf}, 16'h0);
      emask = 12'h000;
      repeat (3) @(negedge clock_in);
      check({15'h0, esf}, 16'h1);
      fault_host_model_i.clr_all();
      done("levels");
      give_verdict();
   end
endmodule : sensor_fault_flag_registers_test
`default_nettype wire
